// file: verilog/kbd_enc_defs.svh
// timing and code constants for the keyboard character encoder
`ifndef KBD_ENC_DEFS_SVH
`define KBD_ENC_DEFS_SVH
`define CLK_HZ            200000000
`define OPS_PER_MIN       368
`define UNIT_HUNDREDTHS   100
`define STOP_HUNDREDTHS   142
`define CHAR_HUNDREDTHS   742
`define CODE_LETTERS      5'h1F
`define CODE_FIGURES      5'h1B
`define CODE_CR           5'h08
`define CODE_LF           5'h02
`define CODE_SPACE        5'h04
`endif

// file: verilog/kbd_enc_pkg.sv
// types for the keyboard character encoder
package kbd_enc_pkg;
  typedef enum logic [3:0] {
    PH_IDLE  = 4'h0,
    PH_START = 4'h1,
    PH_B1    = 4'h2,
    PH_B2    = 4'h3,
    PH_B3    = 4'h4,
    PH_B4    = 4'h5,
    PH_B5    = 4'h6,
    PH_STOP  = 4'h7,
    PH_REL   = 4'h8
  } phase_t;
  typedef enum logic {
    SHIFT_LETTERS = 1'b0,
    SHIFT_FIGURES = 1'b1
  } shift_t;
endpackage

// file: verilog/unit_tick_if.sv
// unit timing enables shared between sequencer and divider
`timescale 1ns/1ps
`default_nettype none
interface unit_tick_if;
  logic run;
  logic stop_phase;
  logic unit_tick;
  logic stop_done;
  modport div (input run, input stop_phase, output unit_tick, output stop_done);
  modport seq (output run, output stop_phase, input unit_tick, input stop_done);
endinterface
`default_nettype wire

// file: verilog/unit_divider.sv
// divider producing unit and stop-length enables
`timescale 1ns/1ps
`default_nettype none
`include "kbd_enc_defs.svh"
module unit_divider #(
  parameter int OPS_PER_MIN = `OPS_PER_MIN,
  parameter int CLK_HZ      = `CLK_HZ
) (
  input wire logic   clk_sys,
  input wire logic   reset_n,
  unit_tick_if.div   tick
);
  // one unit = 60 s / (ops * 7.42)
  localparam longint UNIT_CYC = (longint'(CLK_HZ) * 60 * `UNIT_HUNDREDTHS) /
                                (longint'(OPS_PER_MIN) * `CHAR_HUNDREDTHS);
  localparam longint STOP_CYC = (UNIT_CYC * `STOP_HUNDREDTHS) / `UNIT_HUNDREDTHS;
  localparam int CW = $clog2(STOP_CYC + 1);
  if (OPS_PER_MIN < 1 || UNIT_CYC < 2) begin : g_rate_check
    $error("unit_divider: rate not servable");
  end
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  always_comb begin
    nxt_cnt = '0;
    if (tick.run && !tick.unit_tick && !tick.stop_done) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end
  // counts only while a cycle is coupled
  // stop interval runs its own longer count, unit ticks held off there
  assign tick.unit_tick = tick.run && !tick.stop_phase && (cnt_ff == CW'(UNIT_CYC - 1));
  assign tick.stop_done = tick.run && tick.stop_phase && (cnt_ff == CW'(STOP_CYC - 1));
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // unit_divider
`default_nettype wire

// file: verilog/keyboard_character_encoder.sv
// keyboard front end: key latch, shift state and start-stop cycle
`timescale 1ns/1ps
`default_nettype none
`include "kbd_enc_defs.svh"
module keyboard_character_encoder #(
  parameter int OPS_PER_MIN = `OPS_PER_MIN,
  parameter int NKEYS       = 32
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // operator keys, asynchronous levels
  input  wire logic [NKEYS-1:0]    key_code_in,
  input  wire logic                key_space,
  input  wire logic                key_cr,
  input  wire logic                key_lf,
  input  wire logic                key_letters_shift,
  input  wire logic                key_figures_shift,
  input  wire logic                key_local_cr,
  input  wire logic                key_local_lf,
  input  wire logic                key_local_rev_lf,
  input  wire logic                key_line_break,
  // to signal generator
  output logic [4:0]               code_sel,
  output logic                     cycle_trip,
  output logic                     line_mark,
  output logic                     key_locked,
  output kbd_enc_pkg::shift_t      shift_mode,
  // local functions
  output logic                     local_cr,
  output logic                     local_lf,
  output logic                     local_rev_lf,
  output logic                     line_break
);
  import kbd_enc_pkg::*;
  localparam int NIN = NKEYS + 9;
  // press counter is six bits wide
  if (NKEYS < 1 || NKEYS > 56) begin : g_nkeys_check
    $error("keyboard_character_encoder: NKEYS out of range");
  end

  // code pattern per coded key; never the all-spacing code
  function automatic logic [4:0] key_pattern(input int idx);
    key_pattern = 5'((idx + 4) % 31 + 1);
  endfunction

  // two-stage input synchronisers
  logic [NIN-1:0] sync1_ff;
  logic [NIN-1:0] sync2_ff;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {key_line_break, key_local_rev_lf, key_local_lf, key_local_cr,
                   key_figures_shift, key_letters_shift, key_lf, key_cr, key_space,
                   key_code_in};
      sync2_ff <= sync1_ff;
    end
  end
  logic [NKEYS-1:0] k_code;
  logic k_space, k_cr, k_lf, k_ltr, k_fig, k_lcr, k_llf, k_rlf, k_brk;
  assign {k_brk, k_rlf, k_llf, k_lcr, k_fig, k_ltr, k_lf, k_cr, k_space, k_code} = sync2_ff;

  unit_tick_if tick ();
  unit_divider #(.OPS_PER_MIN(OPS_PER_MIN), .CLK_HZ(`CLK_HZ)) u_div (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .tick    (tick)
  );

  phase_t      phase_ff,  nxt_phase;
  shift_t      shift_ff,  nxt_shift;
  logic [4:0]  code_ff,   nxt_code;
  logic        lock_ff,   nxt_lock;
  logic        mark_ff,   nxt_mark;
  logic        trip_ff,   nxt_trip;
  logic        lcr_ff,    nxt_lcr;
  logic        llf_ff,    nxt_llf;
  logic        rlf_ff,    nxt_rlf;
  logic        brk_ff,    nxt_brk;

  // key decode: count pressed interlocked keys, pick pattern
  logic [5:0] npress;
  logic [4:0] pat;
  logic       want_local_cr;
  logic       want_local_lf;
  always_comb begin
    npress = '0;
    pat    = '0;
    for (int i = 0; i < NKEYS; i++) begin
      if (k_code[i]) begin
        npress = npress + 6'h01;
        pat    = key_pattern(i);
      end
    end
    if (k_space) begin npress = npress + 6'h01; pat = `CODE_SPACE;   end
    if (k_cr)    begin npress = npress + 6'h01; pat = `CODE_CR;      end
    if (k_lf)    begin npress = npress + 6'h01; pat = `CODE_LF;      end
    if (k_ltr)   begin npress = npress + 6'h01; pat = `CODE_LETTERS; end
    if (k_fig)   begin npress = npress + 6'h01; pat = `CODE_FIGURES; end
    want_local_cr = k_lcr;
    want_local_lf = k_llf;
    if (k_lcr) npress = npress + 6'h01;
    if (k_llf) npress = npress + 6'h01;
  end

  assign tick.run = (phase_ff != PH_IDLE) && (phase_ff != PH_REL);
  assign tick.stop_phase = (phase_ff == PH_STOP);

  always_comb begin
    nxt_phase = phase_ff;
    nxt_shift = shift_ff;
    nxt_code  = code_ff;
    nxt_lock  = lock_ff;
    nxt_mark  = mark_ff;
    nxt_trip  = 1'b0;
    nxt_lcr   = 1'b0;
    nxt_llf   = 1'b0;
    nxt_rlf   = k_rlf;
    nxt_brk   = k_brk;
    case (phase_ff)
      PH_IDLE: begin
        nxt_mark = 1'b1;
        if (!lock_ff && npress == 6'h01) begin
          nxt_lock = 1'b1;
          if (want_local_cr || want_local_lf) begin
            nxt_lcr   = want_local_cr;
            nxt_llf   = want_local_lf;
            nxt_phase = PH_REL;
          end else begin
            nxt_code  = pat;
            if (k_ltr) nxt_shift = SHIFT_LETTERS;
            if (k_fig) nxt_shift = SHIFT_FIGURES;
            nxt_trip  = 1'b1;
            nxt_phase = PH_START;
          end
        end else if (lock_ff && npress == 6'h00) begin
          nxt_lock = 1'b0;
        end
      end
      PH_START: begin
        nxt_mark = 1'b0;
        if (tick.unit_tick) nxt_phase = PH_B1;
      end
      PH_B1, PH_B2, PH_B3, PH_B4, PH_B5: begin
        nxt_mark = code_ff[3'(phase_ff - PH_B1)];
        if (tick.unit_tick) nxt_phase = phase_t'(phase_ff + 4'h1);
      end
      PH_STOP: begin
        nxt_mark = 1'b1;
        if (tick.stop_done) begin
          nxt_code  = '0;
          nxt_phase = PH_REL;
        end
      end
      PH_REL: begin
        if (npress == 6'h00) begin
          nxt_lock  = 1'b0;
          nxt_phase = PH_IDLE;
        end
      end
      default: nxt_phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      phase_ff <= PH_IDLE;
      shift_ff <= SHIFT_LETTERS;
      code_ff  <= '0;
      lock_ff  <= 1'b0;
      mark_ff  <= 1'b1;
      trip_ff  <= 1'b0;
      lcr_ff   <= 1'b0;
      llf_ff   <= 1'b0;
      rlf_ff   <= 1'b0;
      brk_ff   <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      shift_ff <= nxt_shift;
      code_ff  <= nxt_code;
      lock_ff  <= nxt_lock;
      mark_ff  <= nxt_mark;
      trip_ff  <= nxt_trip;
      lcr_ff   <= nxt_lcr;
      llf_ff   <= nxt_llf;
      rlf_ff   <= nxt_rlf;
      brk_ff   <= nxt_brk;
    end
  end

  assign code_sel     = code_ff;
  assign cycle_trip   = trip_ff;
  assign line_mark    = mark_ff;
  assign key_locked   = lock_ff;
  assign shift_mode   = shift_ff;
  assign local_cr     = lcr_ff;
  assign local_lf     = llf_ff;
  assign local_rev_lf = rlf_ff;
  assign line_break   = brk_ff;
endmodule // keyboard_character_encoder
`default_nettype wire

// file: testbench/kbd_enc_monitor.sv
// port assertions for the keyboard character encoder
`timescale 1ns/1ps
`default_nettype none
module kbd_enc_monitor #(
  parameter int OPS_PER_MIN = 368,
  parameter int NKEYS       = 32
) (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic [4:0] code_sel,
  input wire logic       cycle_trip,
  input wire logic       line_mark,
  input wire logic       key_locked,
  input wire logic       local_cr,
  input wire logic       local_lf
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_start;
    cycle_trip ##1 !line_mark;
  endsequence
  property p_trip_start; cycle_trip |-> s_start; endproperty
  a_trip_start: assert property (p_trip_start) else $error("no start after trip");
  property p_one_trip; cycle_trip |=> !cycle_trip [*8]; endproperty
  a_one_trip: assert property (p_one_trip) else $error("trip repeated");
  property p_trip_sel; cycle_trip |-> key_locked && code_sel != 5'h00; endproperty
  a_trip_sel: assert property (p_trip_sel) else $error("trip without code");
  property p_trip_idle; cycle_trip |-> $past(code_sel) == 5'h00 && !$past(key_locked); endproperty
  a_trip_idle: assert property (p_trip_idle) else $error("trip while busy");
  property p_sel_hold; code_sel != 5'h00 |=> code_sel == $past(code_sel) || code_sel == 5'h00; endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("code changed mid cycle");
  property p_idle_mark; code_sel == 5'h00 |-> line_mark; endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not marking at idle");
  property p_unlock; $fell(key_locked) |-> code_sel == 5'h00; endproperty
  a_unlock: assert property (p_unlock) else $error("unlock before cycle end");
  property p_local; (local_cr || local_lf) |-> !cycle_trip && code_sel == 5'h00 ##1 !(local_cr || local_lf); endproperty
  a_local: assert property (p_local) else $error("local key misbehaved");
endmodule // kbd_enc_monitor
bind keyboard_character_encoder kbd_enc_monitor #(.OPS_PER_MIN(OPS_PER_MIN), .NKEYS(NKEYS)) kbd_enc_monitor_inst (
  .clk_sys(clk_sys), .reset_n(reset_n), .code_sel(code_sel), .cycle_trip(cycle_trip),
  .line_mark(line_mark), .key_locked(key_locked), .local_cr(local_cr), .local_lf(local_lf));
`default_nettype wire

// file: testbench/line_receiver.sv
// serial line receiver standing in for the far side
`timescale 1ns/1ps
`default_nettype none
module line_receiver #(
  parameter int UNIT = 8
) (
  input  wire logic       clk_sys,
  input  wire logic       line_mark,
  output logic [4:0]      rx_code,
  output logic            rx_ok,
  output int              rx_cnt
);
  initial begin
    rx_cnt = 0;
    rx_code = 5'h00;
    rx_ok = 1'b0;
    forever begin
      @(negedge line_mark);
      repeat (UNIT / 2) @(posedge clk_sys);
      rx_ok = !line_mark;
      for (int k = 0; k < 5; k++) begin
        repeat (UNIT) @(posedge clk_sys);
        rx_code[k] = line_mark;
      end
      repeat (UNIT) @(posedge clk_sys);
      rx_ok = rx_ok && line_mark;
      rx_cnt++;
    end
  end
endmodule // line_receiver
`default_nettype wire

// file: testbench/keyboard_character_encoder_bench.sv
// self-checking bench for the keyboard character encoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module keyboard_character_encoder_bench;
  import kbd_enc_pkg::*;
  localparam int OPS  = 200000000;
  localparam int UNIT = int'(64'd1200000000000 / (64'd742 * OPS));
  logic        clk_sys, reset_n, cycle_trip, line_mark, key_locked;
  logic        local_cr, local_lf, local_rev_lf, line_break, rx_ok;
  logic [40:0] keys;
  logic [4:0]  code_sel, rx_code;
  shift_t      shift_mode;
  int          rx_cnt, trips, lcr, llf, err_total, total_checks;
  keyboard_character_encoder #(.OPS_PER_MIN(OPS)) keyboard_character_encoder_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .key_code_in(keys[31:0]), .key_space(keys[32]),
    .key_cr(keys[33]), .key_lf(keys[34]), .key_letters_shift(keys[35]), .key_figures_shift(keys[36]),
    .key_local_cr(keys[37]), .key_local_lf(keys[38]), .key_local_rev_lf(keys[39]), .key_line_break(keys[40]),
    .code_sel(code_sel), .cycle_trip(cycle_trip), .line_mark(line_mark), .key_locked(key_locked),
    .shift_mode(shift_mode), .local_cr(local_cr), .local_lf(local_lf), .local_rev_lf(local_rev_lf),
    .line_break(line_break));
  line_receiver #(.UNIT(UNIT)) line_receiver_inst (
    .clk_sys(clk_sys), .line_mark(line_mark), .rx_code(rx_code), .rx_ok(rx_ok), .rx_cnt(rx_cnt));
  always @(posedge clk_sys) begin
    trips <= trips + int'(cycle_trip === 1'b1);
    lcr <= lcr + int'(local_cr === 1'b1);
    llf <= llf + int'(local_lf === 1'b1);
  end
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // press, hold until the receiver counts the character (stop interval still running), then release
  task automatic strike(input int k, input logic [4:0] e);
    int t0, r0;
    t0 = trips;
    r0 = rx_cnt;
    @(posedge clk_sys) keys[k] <= 1'b1;
    repeat (5) @(posedge clk_sys);
    #1 `CHK("code_sel", e, code_sel)
    repeat (20 * UNIT) begin
      @(posedge clk_sys);
      #1 if (rx_cnt != r0) break;
    end
    `CHK("rx_code", e, rx_code)
    `CHK("rx_count", r0 + 1, rx_cnt)
    `CHK("rx_frame", 1'b1, rx_ok)
    @(posedge clk_sys) keys[k] <= 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 `CHK("key_locked", 1'b0, key_locked)
    `CHK("trip_count", t0 + 1, trips)
  endtask
  task automatic t_codes();
    for (int i = 0; i < 32; i++) strike(i, 5'((i + 4) % 31 + 1));
    strike(32, 5'h04);
    strike(33, 5'h08);
    strike(34, 5'h02);
    $display("test codes done");
  endtask
  task automatic t_shift();
    strike(36, 5'h1B);
    `CHK("shift", SHIFT_FIGURES, shift_mode)
    strike(0, 5'h05);
    `CHK("shift", SHIFT_FIGURES, shift_mode)
    strike(35, 5'h1F);
    `CHK("shift", SHIFT_LETTERS, shift_mode)
    $display("test shift done");
  endtask
  task automatic t_interlock();
    int t0;
    t0 = trips;
    @(posedge clk_sys) keys[37:36] <= 2'b11;
    repeat (30) @(posedge clk_sys);
    #1 `CHK("trip_count", t0, trips)
    `CHK("key_locked", 1'b0, key_locked)
    @(posedge clk_sys) keys[37:36] <= 2'b00;
    repeat (10) @(posedge clk_sys);
    $display("test interlock done");
  endtask
  task automatic t_local();
    int t0, c0, f0;
    t0 = trips;
    c0 = lcr;
    f0 = llf;
    for (int j = 37; j < 39; j++) begin
      @(posedge clk_sys) keys[j] <= 1'b1;
      repeat (10) @(posedge clk_sys);
      #1 `CHK("line_mark", 1'b1, line_mark)
      @(posedge clk_sys) keys[j] <= 1'b0;
      repeat (10) @(posedge clk_sys);
    end
    #1 `CHK("local_pulses", c0 + f0 + 2, lcr + llf)
    @(posedge clk_sys) keys[40:39] <= 2'b11;
    repeat (6) @(posedge clk_sys);
    #1 `CHK("upper_row", 2'b11, {local_rev_lf, line_break})
    @(posedge clk_sys) keys[40:39] <= 2'b00;
    repeat (6) @(posedge clk_sys);
    #1 `CHK("upper_row", 2'b00, {local_rev_lf, line_break})
    `CHK("trip_count", t0, trips)
    $display("test local done");
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #100us;
    err_total++;
    print_verdict();
  end
  initial begin
    {trips, lcr, llf, err_total, total_checks} = '0;
    keys = '0;
    reset_n = 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_codes();
    t_shift();
    t_interlock();
    t_local();
    print_verdict();
  end
endmodule // keyboard_character_encoder_bench
`default_nettype wire
